// ==== common/stack_ret_regs.svh ====
/*
 Register offsets, field positions, reset values and step sizes
 of the stack return execution block.
 Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
*/
`ifndef STACK_RET_REGS_SVH
`define STACK_RET_REGS_SVH

`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_PCNT      8'h08
`define OFF_SPTR      8'h0C
`define OFF_SWORD     8'h10

`define CTRL_SUB_EXIT 0
`define CTRL_IRQ_EXIT 1

`define STAT_BUSY     0
`define STAT_DONE     1
`define STAT_REFUSED  2

`define SW_CARRY      0
`define SW_ZERO       1
`define SW_NEG        2
`define SW_IRQ_EN     3
`define SW_HALT       4
`define SW_OSC_DIS    5
`define SW_OVFL       8
`define SW_PCHI_LSB   12

`define RST_PCNT      20'h00000
`define RST_SPTR      20'h00000
`define RST_SWORD     16'h0000
`define STACK_STEP    20'h00002

`endif

// ==== common/stack_ret_pkg.sv ====
/*
 Types shared by the stack return execution modules.
 Assumes the constants header is compiled alongside.
*/
package stack_ret_pkg;
   typedef logic [19:0] addr20_t;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SUB_POP,
      ST_SW_POP,
      ST_PC_POP
   } exec_state_e;
endpackage

// ==== common/pop_if.sv ====
/*
 One stack read request between the sequencer and the pop engine.
 Assumes start is a one-cycle pulse and done answers it once.
*/
`timescale 1ns/1ps
`default_nettype none
interface pop_if;
   import stack_ret_pkg::*;
   logic    start;
   addr20_t addr;
   logic    done;
   word_t   data;
   modport ctl (output start, output addr, input done, input data);
   modport eng (input start, input addr, output done, output data);
endinterface
`default_nettype wire

// ==== hdl/pop_engine.sv ====
/*
 Reads one word of the stack from data memory per start pulse.
 Assumes the memory holds mem_rdata valid while mem_ack is high.
*/
`timescale 1ns/1ps
`default_nettype none
module pop_engine
   import stack_ret_pkg::*;
(
   input  wire logic   hclk,       // Core clock
   input  wire logic   hresetn,    // Async reset, low
   pop_if.eng          pop,        // Request from sequencer
   output logic        mem_req,    // Read request, level
   output addr20_t     mem_addr,   // Stack read address
   input  wire word_t  mem_rdata,  // Read data
   input  wire logic   mem_ack     // Read complete
);
   logic  req_r;
   addr20_t addr_r;
   logic  done_r;
   word_t data_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_r  <= 1'b0;
         addr_r <= 20'h00000;
      end else if (pop.start && !req_r) begin
         req_r  <= 1'b1;
         addr_r <= pop.addr;
      end else if (req_r && mem_ack) begin
         req_r  <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_r <= 1'b0;
         data_r <= 16'h0000;
      end else begin
         done_r <= req_r & mem_ack;
         if (req_r && mem_ack)
            data_r <= mem_rdata;
      end
   end

   assign mem_req   = req_r;
   assign mem_addr  = addr_r;
   assign pop.done  = done_r;
   assign pop.data  = data_r;
endmodule
`default_nettype wire

// ==== hdl/ret_target.sv ====
/*
 Forms the 20-bit return address from a popped word.
 Assumes hi_bits were taken from the status word of the same frame.
*/
`timescale 1ns/1ps
`default_nettype none
module ret_target
   import stack_ret_pkg::*;
(
   input  wire logic       from_irq,  // Frame of an interrupt_exit
   input  wire logic [3:0] hi_bits,   // Saved upper address bits
   input  wire word_t      word,      // Popped return word
   output addr20_t         target     // Full return address
);
   assign target = from_irq ? {hi_bits, word}
                            : {4'h0, word};
endmodule
`default_nettype wire

// ==== hdl/stack_return_execution.sv ====
/*
 Return sequencer: subroutine_exit and interrupt_exit, popping from the
 stack in data memory and reloading program counter and status word.
 Assumes an AHB-Lite master with single word transfers, one memory
 port that answers each read with a one-cycle mem_ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stack_ret_regs.svh"

// Operation
// - subroutine_exit loads the word at stack_pointer into PC 15:0.
// - subroutine_exit clears program_counter bits 19 to 16.
// - subroutine_exit adds 2 to stack_pointer after its pop.
// - subroutine_exit keeps the N, Z, C and V flags as they are.
// - subroutine_exit keeps the three mode bits as they are.
// - interrupt_exit pops status_word first, which holds PC 19:16.
// - interrupt_exit pops PC 15:0 next and joins the saved top bits.
// - interrupt_exit adds 2 after each pop, 4 in total.
// - interrupt_exit restores N, C, Z and V from the stack.
// - interrupt_exit restores the three mode bits from the stack.
// - interrupt_exit changes no interrupt flag, only core state.
module stack_return_execution
   import stack_ret_pkg::*;
(
   // Clock, reset and register bus
   input  wire logic        hclk,          // Core clock, 100 MHz
   input  wire logic        hresetn,       // Async reset, low
   input  wire logic        hsel,          // Slave select
   input  wire logic [31:0] haddr,         // Byte address
   input  wire logic [1:0]  htrans,        // Transfer type
   input  wire logic        hwrite,        // Write when high
   input  wire logic [2:0]  hsize,         // Word only
   input  wire logic [31:0] hwdata,        // Write data
   input  wire logic        hready,        // Bus ready in
   output logic [31:0]      hrdata,        // Read data
   output logic             hreadyout,     // Slave ready
   output logic             hresp,         // Always OKAY
   // Stack memory port
   output logic             mem_req,       // Stack read request
   output addr20_t          mem_addr,      // Stack read address
   input  wire word_t       mem_rdata,     // Stack read data
   input  wire logic        mem_ack,       // Stack read done
   // Core state
   output addr20_t          program_counter,  // Current PC
   output addr20_t          stack_pointer,    // Current SP
   output word_t            status_word,      // Current SR
   output logic             oscillator_disable, // Mode bit
   output logic             processor_halt,     // Mode bit
   output logic             global_irq_enable   // Mode bit
);

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction

   pop_if pop ();

   exec_state_e state_r;
   exec_state_e state_nxt;

   addr20_t pc_r;
   addr20_t sp_r;
   word_t   sw_r;
   logic [3:0] pchi_r;
   addr20_t pc_new;

   logic        wr_pend_r;
   logic [7:0]  wr_addr_r;
   logic [31:0] hrdata_r;
   logic        hreadyout_r;
   logic        done_r;
   logic        refused_r;
   logic        last_irq_r;
   wire logic [2:0] mode_r;

   // Bus decode
   wire logic       addr_ph  = hsel & htrans[1] & hready;
   wire logic [7:0] rd_off   = haddr[7:0];
   wire logic       rd_ph    = addr_ph & ~hwrite;
   wire logic       wr_ctrl  = wr_pend_r & hit(wr_addr_r, `OFF_CTRL);
   wire logic       wr_stat  = wr_pend_r & hit(wr_addr_r, `OFF_STATUS);
   wire logic       wr_pc    = wr_pend_r & hit(wr_addr_r, `OFF_PCNT);
   wire logic       wr_sp    = wr_pend_r & hit(wr_addr_r, `OFF_SPTR);
   wire logic       wr_sw    = wr_pend_r & hit(wr_addr_r, `OFF_SWORD);

   // Start requests; both bits at once is refused as ambiguous
   wire logic req_sub  = wr_ctrl & hwdata[`CTRL_SUB_EXIT]
                                 & ~hwdata[`CTRL_IRQ_EXIT];
   wire logic req_irq  = wr_ctrl & hwdata[`CTRL_IRQ_EXIT]
                                 & ~hwdata[`CTRL_SUB_EXIT];
   wire logic req_both = wr_ctrl & hwdata[`CTRL_SUB_EXIT]
                                 & hwdata[`CTRL_IRQ_EXIT];
   wire logic idle     = (state_r == ST_IDLE);
   wire logic busy     = ~idle;
   wire logic go_sub   = idle & req_sub;
   wire logic go_irq   = idle & req_irq;
   wire logic refuse   = (busy & (req_sub | req_irq)) | req_both;

   // Pop completions per state
   wire logic sub_done = (state_r == ST_SUB_POP) & pop.done;
   wire logic sw_done  = (state_r == ST_SW_POP) & pop.done;
   wire logic pc_done  = (state_r == ST_PC_POP) & pop.done;
   wire logic any_pop  = sub_done | sw_done | pc_done;
   wire logic finished = sub_done | pc_done;

   // Second pop starts the cycle the first completes
   assign pop.start = go_sub | go_irq | sw_done;
   assign pop.addr  = sw_done ? addr20_t'(sp_r + `STACK_STEP) : sp_r;

   // Software writes to core state only while idle
   wire logic sw_wr_pc = wr_pc & idle;
   wire logic sw_wr_sp = wr_sp & idle;
   wire logic sw_wr_sw = wr_sw & idle;

   // Read mux, registered at the address phase
   wire logic [31:0] status_view = {29'h0, refused_r, done_r, busy};
   wire logic [31:0] ctrl_view   = {30'h0, last_irq_r, 1'b0};
   wire logic sel_ctrl = hit(rd_off, `OFF_CTRL);
   wire logic sel_stat = hit(rd_off, `OFF_STATUS);
   wire logic sel_pc   = hit(rd_off, `OFF_PCNT);
   wire logic sel_sp   = hit(rd_off, `OFF_SPTR);
   wire logic sel_sw   = hit(rd_off, `OFF_SWORD);
   wire logic [31:0] rd_mux =
      sel_ctrl ? ctrl_view :
      sel_stat ? status_view :
      sel_pc   ? {12'h000, pc_r} :
      sel_sp   ? {12'h000, sp_r} :
      sel_sw   ? {16'h0000, sw_r} :
                 32'h0000_0000;

   pop_engine u_pop (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .pop       (pop.eng),
      .mem_req   (mem_req),
      .mem_addr  (mem_addr),
      .mem_rdata (mem_rdata),
      .mem_ack   (mem_ack)
   );

   ret_target u_tgt (
      .from_irq (pc_done),
      .hi_bits  (pchi_r),
      .word     (pop.data),
      .target   (pc_new)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (go_sub)
               state_nxt = ST_SUB_POP;
            else if (go_irq)
               state_nxt = ST_SW_POP;
         end
         ST_SUB_POP: begin
            if (pop.done)
               state_nxt = ST_IDLE;
         end
         ST_SW_POP: begin
            if (pop.done)
               state_nxt = ST_PC_POP;
         end
         ST_PC_POP: begin
            if (pop.done)
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // Bus data phase bookkeeping; zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_ph & hwrite;
         wr_addr_r <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata_r <= 32'h0000_0000;
      else if (rd_ph)
         hrdata_r <= rd_mux;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hreadyout_r <= 1'b0;
      else
         hreadyout_r <= 1'b1;
   end

   // Program counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pc_r <= `RST_PCNT;
      else if (sub_done)
         pc_r <= pc_new;
      else if (pc_done)
         pc_r <= pc_new;
      else if (sw_wr_pc)
         pc_r <= hwdata[19:0];
   end

   // Stack pointer; word stack, so bit 0 stays clear on writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         sp_r <= `RST_SPTR;
      else if (any_pop)
         sp_r <= addr20_t'(sp_r + `STACK_STEP);
      else if (sw_wr_sp)
         sp_r <= {hwdata[19:1], 1'b0};
   end

   // Status word: of the pops only the first of an interrupt_exit frame touches it; software writes while idle also load it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         sw_r <= `RST_SWORD;
      else if (sw_done)
         sw_r <= pop.data;
      else if (sw_wr_sw)
         sw_r <= hwdata[15:0];
   end
   // Flags and mode bits untouched by sub_done

   // Upper address bits ride in the same word as the flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pchi_r <= 4'h0;
      else if (sw_done)
         pchi_r <= pop.data[`SW_PCHI_LSB +: 4];
   end

   // Mode bits follow the status word one cycle later, one flop each;
   // the lag keeps the outputs registered at the cost of a cycle
   wire logic [2:0] mode_src = {sw_r[`SW_OSC_DIS], sw_r[`SW_HALT],
                                sw_r[`SW_IRQ_EN]};
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_mode
         logic bit_r;
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               bit_r <= 1'b0;
            else
               bit_r <= mode_src[g];
         end
         assign mode_r[g] = bit_r;
      end
   endgenerate

   // Sticky flags, write 1 to clear; a new event wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         done_r <= 1'b0;
      else if (finished)
         done_r <= 1'b1;
      else if (go_sub | go_irq)
         done_r <= 1'b0;
      else if (wr_stat && hwdata[`STAT_DONE])
         done_r <= 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         refused_r <= 1'b0;
      else if (refuse)
         refused_r <= 1'b1;
      else if (wr_stat && hwdata[`STAT_REFUSED])
         refused_r <= 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         last_irq_r <= 1'b0;
      else if (go_sub | go_irq)
         last_irq_r <= go_irq;
   end

   // No interrupt flag exists here to be touched

   assign hrdata             = hrdata_r;
   assign hreadyout          = hreadyout_r;
   assign hresp              = 1'b0;
   assign program_counter    = pc_r;
   assign stack_pointer      = sp_r;
   assign status_word        = sw_r;
   assign oscillator_disable = mode_r[2];
   assign processor_halt     = mode_r[1];
   assign global_irq_enable  = mode_r[0];

endmodule
`default_nettype wire

// ==== dv/stack_ret_props.sv ====
/*
 Checker for the stack return sequencer, bound to its top ports.
 Assumes word bus transfers and one-cycle memory acknowledges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stack_ret_regs.svh"
module stack_ret_props
   import stack_ret_pkg::*;
(
   input wire logic        hclk,      // Clock
   input wire logic        hresetn,   // Reset, low
   input wire logic        hsel,      // Select
   input wire logic [31:0] haddr,     // Address
   input wire logic [1:0]  htrans,    // Type
   input wire logic        hwrite,    // Write
   input wire logic [31:0] hwdata,    // Data
   input wire logic        hready,    // Ready
   input wire logic        hresp,     // Response
   input wire logic        mem_req,   // Read req
   input wire addr20_t     mem_addr,  // Read addr
   input wire word_t       mem_rdata, // Read data
   input wire logic        mem_ack,   // Read done
   input wire addr20_t     program_counter,    // PC
   input wire addr20_t     stack_pointer,      // SP
   input wire word_t       status_word,        // SR
   input wire logic        oscillator_disable, // Mode
   input wire logic        processor_halt,     // Mode
   input wire logic        global_irq_enable   // Mode
);
   logic       wr_dp_r;
   logic [7:0] wr_off_r, land_off_r;
   logic [1:0] op_r, pops_r;
   word_t      first_r, word_r;
   addr20_t    first_addr_r;
   wire ap_wr   = hsel && htrans[1] && hready && hwrite;
   wire pop_ok  = mem_req && mem_ack;
   wire ctrl_wr = wr_dp_r && (wr_off_r == `OFF_CTRL);
   // Offset of a bus write that landed last edge, so bus updates are
   // told apart from pops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dp_r <= 1'b0;
         wr_off_r <= 8'h00;
         land_off_r <= 8'hFF;
         op_r <= 2'b00;
         pops_r <= 2'b00;
         first_r <= 16'h0000;
         word_r <= 16'h0000;
         first_addr_r <= 20'h00000;
      end else begin
         wr_dp_r <= ap_wr;
         wr_off_r <= haddr[7:0];
         land_off_r <= wr_dp_r ? wr_off_r : 8'hFF;
         if (ctrl_wr) begin
            op_r <= hwdata[1:0];
         end
         // Frame count closes itself; a refused start must not reset it
         if (pop_ok) begin
            pops_r <= (op_r == 2'b10 && pops_r == 2'b00) ? 2'b01 : 2'b00;
         end
         if (pop_ok) begin
            word_r <= mem_rdata;
         end
         if (pop_ok && pops_r == 2'b00) begin
            first_r <= mem_rdata;
            first_addr_r <= mem_addr;
         end
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_POP_AT_SP: assert property (
      pop_ok |-> mem_addr == stack_pointer)
      else $error("stack read not at stack pointer");
   AST_SECOND_POP: assert property (pop_ok && pops_r == 2'b01
      |-> mem_addr == first_addr_r + 20'h00002)
      else $error("second pop address wrong");
   AST_SP_STEP: assert property ($changed(stack_pointer)
      && land_off_r != `OFF_SPTR |-> stack_pointer ==
      $past(stack_pointer) + 20'h00002)
      else $error("stack pointer step not two");
   AST_SUB_PC: assert property ($changed(program_counter)
      && land_off_r != `OFF_PCNT && op_r == 2'b01
      |-> program_counter == {4'h0, word_r})
      else $error("subroutine return address wrong");
   AST_IRQ_PC: assert property ($changed(program_counter)
      && land_off_r != `OFF_PCNT && op_r == 2'b10
      |-> program_counter == {first_r[15:12], word_r})
      else $error("interrupt return address wrong");
   AST_SR_FROM_STACK: assert property ($changed(status_word)
      && land_off_r != `OFF_SWORD
      |-> op_r == 2'b10 && status_word == first_r)
      else $error("status word changed without interrupt pop");
   AST_MODE_LAG: assert property (
      {oscillator_disable, processor_halt, global_irq_enable}
      == $past(status_word[5:3]))
      else $error("mode bits do not follow status word");
   AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req
      && $stable(mem_addr))
      else $error("stack read dropped before acknowledge");
   AST_OKAY: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   cover property (pop_ok && op_r == 2'b01);
   cover property (pop_ok && pops_r == 2'b01);
   cover property (mem_req && !mem_ack [*3]);
endmodule
`default_nettype wire

// ==== dv/stack_mem_model.sv ====
/*
 Data memory holding the stack; answers reads after wait_cycles.
 Assumes the bench fills mem before each return.
*/
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model
   import stack_ret_pkg::*;
(
   input  wire logic       hclk,        // Clock
   input  wire logic       hresetn,     // Reset, low
   input  wire logic       mem_req,     // Read req
   input  wire addr20_t    mem_addr,    // Read addr
   input  wire logic [1:0] wait_cycles, // Answer delay
   output word_t           mem_rdata,   // Read data
   output logic            mem_ack      // Read done
);
   word_t      mem [addr20_t];
   word_t      data_r;
   word_t      last_r;
   logic [1:0] cnt_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_ack <= 1'b0;
         cnt_r <= 2'b00;
         data_r <= 16'h0000;
         last_r <= 16'h0000;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         cnt_r <= 2'b00;
         last_r <= data_r;
      end else if (mem_req) begin
         if (cnt_r == wait_cycles) begin
            mem_ack <= 1'b1;
            data_r <= mem.exists(mem_addr) ? mem[mem_addr] : ~last_r;
         end else begin
            cnt_r <= cnt_r + 2'b01;
         end
      end
   end
   // Inverted stale data outside the ack cycle, never a usable value
   assign mem_rdata = mem_ack ? data_r : ~last_r;
endmodule
`default_nettype wire

// ==== dv/tb_stack_return_execution.sv ====
/*
 Bench for the stack return sequencer over AHB-Lite.
 Assumes hreadyout feeds hready and one slave on the bus.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stack_ret_regs.svh"
module tb_stack_return_execution;
   import stack_ret_pkg::*;
   typedef struct {logic [31:0] v; string n;} note_s;
   logic hclk, hresetn, hsel, hwrite, rd_chk, mode_chk;
   logic [31:0] haddr, hwdata, hrdata, got, dmy;
   logic [1:0] htrans, wait_cycles;
   logic hreadyout, hresp, mem_req, mem_ack, osc, halt, irq_en;
   addr20_t mem_addr, pc, sp, exp_sp;
   word_t mem_rdata, sw;
   int bad_count, checked, seed, i;
   note_s notes[$], nt;
   stack_return_execution u_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .program_counter(pc), .stack_pointer(sp),
      .status_word(sw), .oscillator_disable(osc),
      .processor_halt(halt), .global_irq_enable(irq_en));
   stack_mem_model u_mem (.hclk(hclk), .hresetn(hresetn),
      .mem_req(mem_req), .mem_addr(mem_addr), .wait_cycles(wait_cycles),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic c, input string n,
      output logic [31:0] r);
      note_s e;
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= w ? d : 32'h00000000;
      if (!w && c) begin
         e.v = d;
         e.n = n;
         notes.push_back(e);
         rd_chk <= 1'b1;
      end
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
      rd_chk <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 1'b0, "", dmy);
   endtask
   task automatic rx(input logic [7:0] a, input logic [31:0] d, string n);
      bus(1'b0, a, d, 1'b1, n, dmy);
   endtask
   // Results are judged where they appear, oldest note first
   always @(posedge hclk) begin
      if (rd_chk || mode_chk) begin
         got = rd_chk ? hrdata : {29'h0, osc, halt, irq_en};
         nt = notes.pop_front();
         checked++;
         if (got !== nt.v) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nt.n, nt.v, got);
         end
      end
   end
   task automatic run_op(input logic [1:0] op);
      addr20_t s0;
      word_t w0, w1, r0, esr;
      logic [31:0] st;
      addr20_t epc;
      note_s m;
      int n;
      s0 = 20'($random(seed)) & 20'h7FFFE;
      w0 = 16'($random(seed));
      w1 = 16'($random(seed));
      r0 = 16'($random(seed));
      u_mem.mem[s0] = w0;
      u_mem.mem[s0 + 20'h00002] = w1;
      wait_cycles <= 2'($random(seed));
      wr(`OFF_SPTR, {12'h000, s0});
      wr(`OFF_SWORD, {16'h0000, r0});
      wr(`OFF_PCNT, 32'h000F0000 | 32'(r0));
      wr(`OFF_CTRL, {30'h0, op});
      // Second start lands while the first is still popping
      wr(`OFF_CTRL, {30'h0, op});
      n = 0;
      do begin
         bus(1'b0, `OFF_STATUS, 32'h0, 1'b0, "", st);
         n++;
      end while (st[`STAT_DONE] !== 1'b1 && n < 40);
      if (st[`STAT_DONE] !== 1'b1) begin
         bad_count++;
         $display("CHECK FAILED done_poll expected 1 seen %b",
            st[`STAT_DONE]);
      end
      esr = op[1] ? w0 : r0;
      epc = op[1] ? {w0[15:12], w1} : {4'h0, w0};
      exp_sp = s0 + (op[1] ? 20'h00004 : 20'h00002);
      rx(`OFF_PCNT, {12'h0, epc}, "pc");
      rx(`OFF_SPTR, {12'h0, exp_sp}, "sp");
      rx(`OFF_SWORD, {16'h0, esr}, "status_word");
      m.v = {29'h0, esr[5:3]};
      m.n = "mode_bits";
      notes.push_back(m);
      mode_chk <= 1'b1;
      @(posedge hclk);
      mode_chk <= 1'b0;
      rx(`OFF_CTRL, {30'h0, op[1], 1'b0}, "ctrl");
      rx(`OFF_STATUS, 32'h6, "status");
      wr(`OFF_STATUS, 32'h6);
   endtask
   task automatic tally_and_finish;
      if (bad_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      tally_and_finish;
   end
   initial begin
      seed = 23224;
      {hresetn, hsel, hwrite, rd_chk, mode_chk} = 5'h00;
      {haddr, hwdata, htrans, wait_cycles} = 68'h0;
      bad_count = 0;
      checked = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      wr(8'h40, 32'hFFFFFFFF);
      rx(8'h40, 32'h0, "unmapped");
      rx(`OFF_PCNT, {12'h0, `RST_PCNT}, "pc_reset");
      rx(`OFF_SPTR, {12'h0, `RST_SPTR}, "sp_reset");
      rx(`OFF_SWORD, {16'h0, `RST_SWORD}, "sr_reset");
      for (i = 0; i < 8; i++) run_op(i[0] ? 2'b10 : 2'b01);
      wr(`OFF_CTRL, 32'h3);
      rx(`OFF_STATUS, 32'h4, "refused");
      rx(`OFF_SPTR, {12'h0, exp_sp}, "sp_kept");
      tally_and_finish;
   end
endmodule
bind stack_return_execution stack_ret_props u_props (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hresp(hresp),
   .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
   .mem_ack(mem_ack), .program_counter(program_counter),
   .stack_pointer(stack_pointer), .status_word(status_word),
   .oscillator_disable(oscillator_disable),
   .processor_halt(processor_halt),
   .global_irq_enable(global_irq_enable));
`default_nettype wire
